//--- rtl/osdf_defs.vh
// constants for the osd background and character format block
`ifndef OSDF_DEFS_VH
`define OSDF_DEFS_VH
// register byte addresses
`define OSDF_BGCOL_ADDR 8'h00
`define OSDF_DOTDIV_ADDR 8'h04
`define OSDF_FMT_ADDR 8'h08
`define OSDF_STAT_ADDR 8'h0c
// background colour field
`define OSDF_BG_RED_BIT 2
`define OSDF_BG_GREEN_BIT 1
`define OSDF_BG_BLUE_BIT 0
`define OSDF_BG_RESET 3'h1
// dot clock divider
`define OSDF_DIV_W 7
`define OSDF_DIV_RESET 7'h40
// format register fields
`define OSDF_MODE_LO 0
`define OSDF_MODE_HI 1
`define OSDF_SIZE_LO 2
`define OSDF_SIZE_HI 3
`define OSDF_SPACE_LO 4
`define OSDF_SPACE_HI 5
`define OSDF_EN_BIT 6
// display modes
`define OSDF_MODE_SUPER 2'h0
`define OSDF_MODE_NORTH 2'h1
`define OSDF_MODE_BOX 2'h2
`define OSDF_MODE_FRAME 2'h3
// cell geometry
`define OSDF_CELL_W 12
`define OSDF_CELL_H 18
`define OSDF_SPACE_STEP 4
// axi responses
`define OSDF_RESP_OKAY 2'h0
`define OSDF_RESP_SLVERR 2'h2
`endif

//--- rtl/osdf_dot_clock.v
// hsync-locked osd dot clock generator
`timescale 1ns/1ns
`include "osdf_defs.vh"
module osdf_dot_clock #(
	parameter DIV_W = `OSDF_DIV_W
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire enable,
	input wire [DIV_W-1:0] divider,
	input wire hsync_rise,
	// dot tick
	output reg dot_tick_r
);
	reg [DIV_W-1:0] cnt_r;
	reg [DIV_W-1:0] cnt_nxt;
	reg tick_nxt;

	// [R06] phase restarts at hsync
	always @* begin
		cnt_nxt = cnt_r;
		tick_nxt = 1'b0;
		if (!enable || hsync_rise) begin
			cnt_nxt = {DIV_W{1'b0}};
		end else if (cnt_r >= divider) begin
			cnt_nxt = {DIV_W{1'b0}};
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	// [R05] width from divider only
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= {DIV_W{1'b0}};
			dot_tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			dot_tick_r <= tick_nxt;
		end
	end
endmodule // osdf_dot_clock

//--- rtl/osdf_core.v
// osd background colour and character format engine with axi4-lite registers
// Behaviour
// [R01] three bits select red, green, blue background
// [R02] background resets to blue
// [R03] background visible only in frame mode
// [R04] upper five colour bits reserved
// [R05] character width set by divider only
// [R06] dot clock restarts on each hsync
// [R07] character cell twelve dots wide
// [R08] cell eighteen dots high, rows repeated
// [R09] line spacing 0, 4, 8, 12
// [R10] vertical size one to four lines
// [R11] software picks size per resolution
// [R12] frame mode fills screen with background
// [R13] mode code three selects frame shadowing
// [R14] colour change applies from next frame
`timescale 1ns/1ns
`include "osdf_defs.vh"
module osdf_core #(
	parameter DIV_W = `OSDF_DIV_W
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// video timing in
	input wire hsync,
	input wire vsync,
	input wire char_pixel,
	// video colour out
	output reg video_red_r,
	output reg video_green_r,
	output reg video_blue_r,
	output reg fast_blank_r,
	output reg dot_tick
);
	reg [2:0] bg_pend_r;
	reg [2:0] bg_live_r;
	reg [DIV_W-1:0] dot_clock_divider_r;
	reg [6:0] fmt_r;
	reg [3:0] dot_col_r;
	reg [4:0] dot_row_r;
	reg [1:0] size_rep_r;
	reg [3:0] gap_r;
	reg hs_d_r;
	reg vs_d_r;
	reg [7:0] aw_addr_r;
	reg aw_have_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg w_have_r;
	wire hs_rise;
	wire vs_rise;
	wire tick;
	wire do_write;
	wire do_read;
	wire [1:0] mode_sel;
	wire [1:0] size_sel;
	wire [1:0] space_sel;
	wire in_gap;
	wire [14:0] stat_word;

	// one-hot style address check shared by both channels
	function is_mapped;
		input [7:0] a;
		begin
			is_mapped = (a == `OSDF_BGCOL_ADDR) || (a == `OSDF_DOTDIV_ADDR) ||
				(a == `OSDF_FMT_ADDR) || (a == `OSDF_STAT_ADDR);
		end
	endfunction

	// read-back word for one aligned register address
	function [31:0] read_word;
		input [7:0] a;
		input [2:0] bg;
		input [DIV_W-1:0] dv;
		input [6:0] fm;
		input [14:0] st;
		begin
			case (a)
				// [R04] reserved bits read zero
				`OSDF_BGCOL_ADDR: read_word = {29'h0, bg};
				`OSDF_DOTDIV_ADDR: read_word = {{(32-DIV_W){1'b0}}, dv};
				`OSDF_FMT_ADDR: read_word = {25'h0, fm};
				`OSDF_STAT_ADDR: read_word = {17'h0, st};
				default: read_word = 32'h0;
			endcase
		end
	endfunction

	// live colour, repeat count, row, column and gap flag
	assign stat_word = {bg_live_r, size_rep_r, dot_row_r, dot_col_r, in_gap};

	assign hs_rise = hsync & ~hs_d_r;
	assign vs_rise = vsync & ~vs_d_r;
	// [R13] mode select pair
	assign mode_sel = {fmt_r[`OSDF_MODE_HI], fmt_r[`OSDF_MODE_LO]};
	assign size_sel = fmt_r[`OSDF_SIZE_HI:`OSDF_SIZE_LO];
	assign space_sel = fmt_r[`OSDF_SPACE_HI:`OSDF_SPACE_LO];
	assign in_gap = (gap_r != 4'h0);

	osdf_dot_clock #(
		.DIV_W(DIV_W)
	) u_dot (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(fmt_r[`OSDF_EN_BIT]),
		.divider(dot_clock_divider_r),
		.hsync_rise(hs_rise),
		.dot_tick_r(tick)
	);

	// axi slave: address and data captured in either order
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && !s_axi_rvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `OSDF_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `OSDF_RESP_OKAY;
			s_axi_rdata <= 32'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr_r) ? `OSDF_RESP_OKAY : `OSDF_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= is_mapped({s_axi_araddr[7:2], 2'b00}) ?
					`OSDF_RESP_OKAY : `OSDF_RESP_SLVERR;
				s_axi_rdata <= read_word({s_axi_araddr[7:2], 2'b00}, bg_pend_r,
					dot_clock_divider_r, fmt_r, stat_word);
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// register file
	always @(posedge aclk) begin
		if (!aresetn) begin
			// [R02] default blue
			bg_pend_r <= `OSDF_BG_RESET;
			dot_clock_divider_r <= `OSDF_DIV_RESET;
			fmt_r <= 7'h40;
		end else if (do_write && w_strb_r[0]) begin
			case (aw_addr_r)
				// [R04] upper bits dropped
				`OSDF_BGCOL_ADDR: bg_pend_r <= w_data_r[2:0];
				`OSDF_DOTDIV_ADDR: dot_clock_divider_r <= w_data_r[DIV_W-1:0];
				`OSDF_FMT_ADDR: fmt_r <= w_data_r[6:0];
				default: fmt_r <= fmt_r;
			endcase
		end
	end

	// [R14] colour latched at frame start
	always @(posedge aclk) begin
		if (!aresetn) begin
			bg_live_r <= `OSDF_BG_RESET;
			hs_d_r <= 1'b0;
			vs_d_r <= 1'b0;
		end else begin
			hs_d_r <= hsync;
			vs_d_r <= vsync;
			if (vs_rise) begin
				bg_live_r <= bg_pend_r;
			end
		end
	end

	// [R07] twelve-dot column counter
	always @(posedge aclk) begin
		if (!aresetn) begin
			dot_col_r <= 4'h0;
		end else if (hs_rise) begin
			dot_col_r <= 4'h0;
		end else if (tick) begin
			dot_col_r <= (dot_col_r == `OSDF_CELL_W - 1) ? 4'h0 : dot_col_r + 4'h1;
		end
	end

	// [R08] [R10] [R09] row, repeat and spacing
	always @(posedge aclk) begin
		if (!aresetn) begin
			dot_row_r <= 5'h0;
			size_rep_r <= 2'h0;
			gap_r <= 4'h0;
		end else if (vs_rise) begin
			dot_row_r <= 5'h0;
			size_rep_r <= 2'h0;
			gap_r <= 4'h0;
		end else if (hs_rise) begin
			if (in_gap) begin
				gap_r <= gap_r - 4'h1;
			end else if (size_rep_r != size_sel) begin
				size_rep_r <= size_rep_r + 2'h1;
			end else begin
				size_rep_r <= 2'h0;
				if (dot_row_r == `OSDF_CELL_H - 1) begin
					dot_row_r <= 5'h0;
					// spacing code times four lines
					gap_r <= {space_sel, 2'b00};
				end else begin
					dot_row_r <= dot_row_r + 5'h1;
				end
			end
		end
	end

	// colour mixer
	always @(posedge aclk) begin
		if (!aresetn) begin
			video_red_r <= 1'b0;
			video_green_r <= 1'b0;
			video_blue_r <= 1'b0;
			fast_blank_r <= 1'b0;
		end else if (char_pixel && !in_gap) begin
			video_red_r <= 1'b1;
			video_green_r <= 1'b1;
			video_blue_r <= 1'b1;
			fast_blank_r <= 1'b1;
		end else if (mode_sel == `OSDF_MODE_FRAME && fmt_r[`OSDF_EN_BIT]) begin
			// [R12] [R03] [R01] frame fill colour
			video_red_r <= bg_live_r[`OSDF_BG_RED_BIT];
			video_green_r <= bg_live_r[`OSDF_BG_GREEN_BIT];
			video_blue_r <= bg_live_r[`OSDF_BG_BLUE_BIT];
			fast_blank_r <= 1'b1;
		end else begin
			video_red_r <= 1'b0;
			video_green_r <= 1'b0;
			video_blue_r <= 1'b0;
			fast_blank_r <= 1'b0;
		end
	end

	always @* begin
		dot_tick = tick;
	end
endmodule // osdf_core

//--- test/osdf_core_asserts.sv
// port checker for the osd core
`timescale 1ns/1ns
module osdf_core_asserts (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// write side
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	// read side
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// dots
	input wire dot_tick
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	a_err_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
		else $error("error read data not zero");
	a_unmap_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0f
		|=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
	a_tick_pulse: assert property (dot_tick |=> !dot_tick)
		else $error("dot tick too long");
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (dot_tick);
endmodule // osdf_core_asserts
bind osdf_core osdf_core_asserts chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .dot_tick);

//--- test/osdf_video_src.sv
// monitor sync and font dot source
`timescale 1ns/1ns
module osdf_video_src (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// control
	input wire slow,
	input wire pix_en,
	// sync and dots
	output wire hsync,
	output wire vsync,
	output wire char_pixel
);
	reg [7:0] hc_r;
	reg [4:0] vc_r;
	// slow doubles the line length
	always @(posedge aclk) begin
		if (!aresetn) begin
			hc_r <= 8'h0;
			vc_r <= 5'h0;
		end else begin
			hc_r <= (hc_r >= (slow ? 8'hc7 : 8'h63)) ? 8'h0 : hc_r + 8'h1;
			if (hc_r == 8'h0)
				vc_r <= vc_r + 5'h1;
		end
	end
	assign hsync = hc_r > 8'h9;
	assign vsync = vc_r == 5'h0;
	assign char_pixel = pix_en;
endmodule // osdf_video_src

//--- test/tb_osdf_core.sv
// self-checking bench for the osd core
`timescale 1ns/1ns
`include "osdf_defs.vh"
module tb_osdf_core;
	logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, pix_en = 1'h0, hs_d = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, p = 3'h1;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic hsync, vsync, char_pixel, video_red_r, video_green_r, video_blue_r;
	logic fast_blank_r, dot_tick;
	logic [6:0] f;
	int miscompares = 0, checks = 0, gap = 0, hc = 0, per = 0, pchk = 0, d, cnt = 0;
	wire [3:0] vid = {fast_blank_r, video_red_r, video_green_r, video_blue_r};
	osdf_core uut (.*);
	osdf_video_src vsrc (.*);
	always #20 aclk = ~aclk;
	function automatic logic [3:0] bg_out(input logic [2:0] c);
		return {1'h1, c[2], c[1], c[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata & m, e);
		chk(s_axi_rresp, er);
	endtask
	// dot spacing away from the line start
	always @(posedge aclk) begin
		hs_d <= hsync;
		hc <= (hsync && !hs_d) ? 0 : hc + 1;
		gap <= dot_tick ? 1 : gap + 1;
		if (dot_tick && pchk && hc - gap > 8)
			chk(gap, per);
	end
	initial begin
		d = $urandom(74);
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`OSDF_BGCOL_ADDR, 32'h7, 32'h1, `OSDF_RESP_OKAY);
		rd(`OSDF_FMT_ADDR, 32'h7f, 32'h40, `OSDF_RESP_OKAY);
		rd(`OSDF_DOTDIV_ADDR, 32'h7f, 32'h40, `OSDF_RESP_OKAY);
		rd(8'h40, 32'hffffffff, 32'h0, `OSDF_RESP_SLVERR);
		wr(8'h44, 32'h7, `OSDF_RESP_SLVERR);
		wr(`OSDF_FMT_ADDR, 32'h43, `OSDF_RESP_OKAY);
		@(negedge vsync);
		repeat (4) @(posedge aclk);
		chk(vid, bg_out(3'h1));
		for (int i = 0; i < 8; i++) begin
			@(negedge vsync);
			wr(`OSDF_BGCOL_ADDR, {24'h0, 5'($urandom), i[2:0]}, `OSDF_RESP_OKAY);
			chk(vid, bg_out(p));
			@(posedge vsync);
			repeat (4) @(posedge aclk);
			chk(vid, bg_out(i[2:0]));
			rd(`OSDF_BGCOL_ADDR, 32'h7, i, `OSDF_RESP_OKAY);
			p = i[2:0];
		end
		pix_en <= 1'h1;
		repeat (8) @(posedge aclk);
		chk(vid, 4'hf);
		pix_en <= 1'h0;
		for (int m = 0; m < 4; m++) begin
			wr(`OSDF_FMT_ADDR, 32'h40 | m, `OSDF_RESP_OKAY);
			repeat (8) @(posedge aclk);
			chk(vid, (m == 3) ? bg_out(p) : 4'h0);
		end
		repeat (6) begin
			f = 7'h40 | 7'($urandom);
			wr(`OSDF_FMT_ADDR, {25'h0, f}, `OSDF_RESP_OKAY);
			rd(`OSDF_FMT_ADDR, 32'h7f, f, `OSDF_RESP_OKAY);
		end
		pix_en <= 1'h1;
		for (int s = 1; s < 4; s++) begin
			wr(`OSDF_FMT_ADDR, 32'h40 | (s << 4), `OSDF_RESP_OKAY);
			@(posedge vsync);
			cnt = 0;
			repeat (3200) begin
				@(posedge aclk);
				if (!fast_blank_r)
					cnt++;
			end
			chk(cnt, s * 400);
		end
		pix_en <= 1'h0;
		wr(`OSDF_FMT_ADDR, 32'h48, `OSDF_RESP_OKAY);
		rd(`OSDF_FMT_ADDR, 32'h7f, 32'h48, `OSDF_RESP_OKAY);
		for (int k = 0; k < 4; k++) begin
			slow <= k[0];
			d = 3 + $urandom % 7;
			wr(`OSDF_DOTDIV_ADDR, d, `OSDF_RESP_OKAY);
			per <= d + 1;
			repeat (250) @(posedge aclk);
			pchk <= 1;
			repeat (500) @(posedge aclk);
			pchk <= 0;
		end
		end_of_test();
	end
	initial begin
		repeat (80000) @(posedge aclk);
		miscompares++;
		end_of_test();
	end
endmodule // tb_osdf_core
